// file: design/sfo_pkg.sv
// ************************************************************
// shared constants of the serial flash security and power block
// ************************************************************
package sfo_pkg;

   // ************************************************************
   // opcodes
   // ************************************************************
   localparam logic [7:0] OP_NONE = 8'h00;
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_WRDI = 8'h04;
   localparam logic [7:0] OP_STATUS = 8'h05;
   localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
   localparam logic [7:0] OP_RELEASE = 8'hAB;
   localparam logic [7:0] OP_SEC_READ = 8'h48;
   localparam logic [7:0] OP_SEC_ERASE = 8'h44;
   localparam logic [7:0] OP_SEC_PROG = 8'h42;

   // ************************************************************
   // frame bit counts and address layout
   // ************************************************************
   localparam logic [5:0] CNT_OP = 6'h08;     // opcode complete
   localparam logic [5:0] CNT_ADDR = 6'h20;   // opcode plus three bytes
   localparam logic [5:0] CNT_DATA = 6'h28;   // first data byte or dummy done
   localparam int unsigned REG_BYTES = 1024;
   localparam int unsigned REG_COUNT = 3;
   localparam logic [11:0] ERASE_END = 12'hC00;

   // arbitrary identity value, no meaning beyond tests
   localparam logic [7:0] DEV_ID_DEFAULT = 8'h5A;

   // ************************************************************
   // timing, clock period 4 ns
   // ************************************************************
   localparam int unsigned CLK_NS = 4;
   localparam int unsigned PD_ENTRY_NS = 3000;
   localparam int unsigned RELEASE_1_NS = 3000;
   localparam int unsigned RELEASE_2_NS = 1800;
   localparam int unsigned ERASE_US = 1000;
   localparam int unsigned PROGRAM_US = 500;
   // longest time rounds down
   localparam int unsigned PD_ENTRY_CYC = PD_ENTRY_NS / CLK_NS;
   // least times round up
   localparam int unsigned RELEASE_1_CYC = (RELEASE_1_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned RELEASE_2_CYC = (RELEASE_2_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned ERASE_CYC = (ERASE_US * 1000) / CLK_NS;
   localparam int unsigned PROGRAM_CYC = (PROGRAM_US * 1000) / CLK_NS;
   // host side: half serial clock period and chip select rest
   localparam int unsigned SCK_HALF_CYC = 6;
   localparam int unsigned CS_GAP_CYC = RELEASE_1_CYC + 8;

endpackage : sfo_pkg

// file: design/sfo_spi_if.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// serial link between controller and flash
// ************************************************************
interface sfo_spi_if;
   logic csN;
   logic sck;
   logic mosi;
   logic misoDrive;
   logic misoOe;
   logic miso;

   // the data line idles high while the flash does not drive it
   assign miso = misoOe ? misoDrive : 1'b1;

   modport device(input csN, input sck, input mosi, output misoDrive, output misoOe);
   modport host(output csN, output sck, output mosi, input miso);
endinterface : sfo_spi_if
`default_nettype wire

// file: design/sfo_flash_dev.sv
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RQ1: power-down opcode only with exactly eight bits
// RQ2: power-down state reached within entry delay
// RQ3: powered down, accept only release or reset
// RQ4: reset leaves device in standby, awake
// RQ5: release opcode, then stay idle release_delay_1
// RQ6: release with dummies returns ID repeatedly
// RQ7: release with ID read waits release_delay_2
// RQ8: release ignored while write in progress
// RQ9: read opcode, address, dummy, then data out
// RQ10: read offset increments, wraps 3FF to 000
// RQ11: three 1024-byte registers, fixed address layout
// RQ12: erase needs write enable latch set
// RQ13: erase only with exactly eight bits
// RQ14: erase self-timed, progress flag set meanwhile
// RQ15: write enable latch cleared by write cycles
// RQ16: global lock bit blocks all erases
// RQ17: program opcode, address, data, needs latch
// RQ18: at most 256 bytes per program
// RQ19: program self-timed, progress flag set meanwhile
// RQ20: locked register ignores program commands
// RQ21: register data leaves most significant first
module sfo_flash_dev
   import sfo_pkg::*;
#(
   parameter int unsigned ENTRY_CYC = PD_ENTRY_CYC,
   parameter int unsigned REL1_CYC = RELEASE_1_CYC,
   parameter int unsigned REL2_CYC = RELEASE_2_CYC,
   parameter int unsigned SE_CYC = ERASE_CYC,
   parameter int unsigned PP_CYC = PROGRAM_CYC,
   parameter logic [7:0] DEVICE_ID = DEV_ID_DEFAULT
)(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // serial link
   sfo_spi_if.device link,
   // one-time lock bits
   input wire logic securityLockBit,
   input wire logic [3:1] registerLock,
   // state seen by the system
   output logic deepPowerDown,
   output logic writeInProgress,
   output logic writeEnableLatch
);

   typedef enum logic [2:0] {M_IDLE, M_ENTRY, M_RELEASE, M_ERASE, M_PROGRAM} sfo_mode_t;

   // ************************************************************
   // pin synchronisers and edge finding
   // ************************************************************
   logic [2:0] pinMeta_reg;
   logic [2:0] pinSync_reg;
   logic [2:0] pinPrev_reg;

   // order is chip select, serial clock, data in
   always_ff @(posedge clock) begin
      if (rst) begin
         pinMeta_reg <= 3'h4;
         pinSync_reg <= 3'h4;
         pinPrev_reg <= 3'h4;
      end else begin
         pinMeta_reg <= {link.csN, link.sck, link.mosi};
         pinSync_reg <= pinMeta_reg;
         pinPrev_reg <= pinSync_reg;
      end
   end

   wire csHigh = pinSync_reg[2];
   wire mosiBit = pinSync_reg[0];
   wire sckRise = ~csHigh & pinSync_reg[1] & ~pinPrev_reg[1];
   wire sckFall = ~csHigh & ~pinSync_reg[1] & pinPrev_reg[1];
   wire csRise = csHigh & ~pinPrev_reg[2];

   // ************************************************************
   // state registers
   // ************************************************************
   sfo_mode_t mode_reg;
   logic [31:0] timer_reg;
   logic pd_reg;
   logic wel_reg;
   logic [11:0] eraseIdx_reg;
   logic [7:0] shIn_reg;
   logic [5:0] bitCnt_reg;
   logic [2:0] bitPos_reg;
   logic [7:0] opcode_reg;
   logic [15:0] addr_reg;
   logic [9:0] off_reg;
   logic [1:0] selM1_reg;
   logic addrOk_reg;
   logic progOk_reg;
   logic progWrote_reg;
   logic [7:0] tx_reg;
   logic outEn_reg;

   // register contents; three registers side by side
   logic [7:0] mem [0:REG_COUNT*REG_BYTES-1];

   // storage starts erased; it holds data, not control state
   initial begin
      for (int i = 0; i < REG_COUNT * REG_BYTES; i++) begin
         mem[i] = 8'hFF;
      end
   end

   // ************************************************************
   // command decode
   // ************************************************************
   wire write_in_progress = (mode_reg == M_ERASE) | (mode_reg == M_PROGRAM);
   wire pdMoving = (mode_reg == M_ENTRY) | (mode_reg == M_RELEASE);

   // which opcodes are heard in the present state
   function automatic logic opHeard(input logic [7:0] op, input logic pd,
                                    input logic moving, input logic busy);
      logic heard;
      heard = 1'b0;
      if (moving) begin
         heard = 1'b0; // see RQ5
      end else if (pd) begin
         heard = (op == OP_RELEASE); // see RQ3
      end else if (op == OP_STATUS) begin
         heard = 1'b1; // status stays readable, see RQ14
      end else if (op == OP_RELEASE || op == OP_SEC_READ || op == OP_WREN ||
                   op == OP_WRDI || op == OP_POWER_DOWN || op == OP_SEC_ERASE ||
                   op == OP_SEC_PROG) begin
         heard = ~busy; // see RQ8
      end
      return heard;
   endfunction : opHeard

   wire [7:0] shNext = {shIn_reg[6:0], mosiBit};
   wire byteDone = sckRise & (bitPos_reg == 3'h7);
   wire [5:0] bitCntNext = (bitCnt_reg == CNT_DATA) ? CNT_DATA : bitCnt_reg + 6'h01;
   wire opDone = byteDone & (bitCntNext == CNT_OP);
   wire addrByte = byteDone & (bitCntNext > CNT_OP) & (bitCntNext <= CNT_ADDR);
   wire addrDone = byteDone & (bitCntNext == CNT_ADDR);
   wire dataByte = byteDone & (bitCntNext == CNT_DATA);
   wire exactOpcode = (bitCnt_reg == CNT_OP) & (bitPos_reg == 3'h0);

   // address checks on the full 24 bits as the last byte lands
   wire [23:0] addrFull = {addr_reg, shNext};
   wire [1:0] regSel = addrFull[13:12];
   wire addrValid = (addrFull[23:14] == 10'h000) & (regSel != 2'h0) &
                    (addrFull[11:10] == 2'h0); // see RQ11
   wire regLocked = registerLock[regSel]; // see RQ20

   // ************************************************************
   // register port: erase walk has priority over program bytes
   // ************************************************************
   wire eraseWr = (mode_reg == M_ERASE) & (eraseIdx_reg != ERASE_END);
   wire progWr = dataByte & progOk_reg & (opcode_reg == OP_SEC_PROG);
   wire [11:0] memIdx = eraseWr ? eraseIdx_reg : {selM1_reg, off_reg};
   wire [7:0] memRd = mem[memIdx];
   // programming can only clear bits, as in the array itself
   wire [7:0] memWrData = eraseWr ? 8'hFF : (memRd & shNext);

   always_ff @(posedge clock) begin
      if (eraseWr | progWr) begin
         mem[memIdx] <= memWrData;
      end
   end

   // ************************************************************
   // output byte selection
   // ************************************************************
   wire outStatus = (opcode_reg == OP_STATUS) & (bitCnt_reg >= CNT_OP);
   wire outId = (opcode_reg == OP_RELEASE) & (bitCnt_reg >= CNT_ADDR); // see RQ6
   wire outRead = (opcode_reg == OP_SEC_READ) & (bitCnt_reg == CNT_DATA); // see RQ9
   wire outPhase = outStatus | outId | outRead;
   wire loadNow = sckFall & outPhase & (bitPos_reg == 3'h0);
   wire [7:0] loadByte = outStatus ? {6'h00, wel_reg, write_in_progress} :
                         outId ? DEVICE_ID :
                         addrOk_reg ? memRd : 8'hFF;

   // ************************************************************
   // serial shifter, bit counting and output
   // ************************************************************
   always_ff @(posedge clock) begin
      if (rst || csRise) begin
         shIn_reg <= 8'h00;
         bitCnt_reg <= 6'h00;
         bitPos_reg <= 3'h0;
         opcode_reg <= OP_NONE;
         addr_reg <= 16'h0000;
         off_reg <= 10'h000;
         selM1_reg <= 2'h0;
         addrOk_reg <= 1'b0;
         progOk_reg <= 1'b0;
         progWrote_reg <= 1'b0;
         tx_reg <= 8'hFF;
         outEn_reg <= 1'b0;
      end else begin
         if (sckRise) begin
            shIn_reg <= shNext;
            bitCnt_reg <= bitCntNext;
            bitPos_reg <= bitPos_reg + 3'h1;
         end
         if (opDone) begin
            // unheard opcodes leave the frame dead until chip select rises
            opcode_reg <= opHeard(shNext, pd_reg, pdMoving, write_in_progress) ? shNext : OP_NONE;
         end
         if (addrByte) begin
            addr_reg <= addrFull[15:0];
         end
         if (addrDone) begin
            off_reg <= addrFull[9:0];
            selM1_reg <= regSel - 2'h1;
            addrOk_reg <= addrValid;
            progOk_reg <= addrValid & ~regLocked & wel_reg; // see RQ17
         end
         if (progWr) begin
            // offset wraps inside a 256-byte window, see RQ18
            off_reg <= {off_reg[9:8], off_reg[7:0] + 8'h01};
            progWrote_reg <= 1'b1;
         end
         if (loadNow) begin
            tx_reg <= loadByte; // see RQ21
            outEn_reg <= 1'b1;
            if (outRead) begin
               off_reg <= off_reg + 10'h001; // see RQ10
            end
         end else if (sckFall & outEn_reg) begin
            tx_reg <= {tx_reg[6:0], 1'b1};
         end
      end
   end

   // ************************************************************
   // self-timed cycles, power state and write enable latch
   // ************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         mode_reg <= M_IDLE;
         timer_reg <= 32'h0000_0000;
         pd_reg <= 1'b0; // see RQ4
         wel_reg <= 1'b0;
         eraseIdx_reg <= 12'h000;
      end else if (mode_reg != M_IDLE) begin
         if (eraseWr) begin
            eraseIdx_reg <= eraseIdx_reg + 12'h001;
         end
         if (timer_reg == 32'h0000_0000) begin
            mode_reg <= M_IDLE;
            if (mode_reg == M_ENTRY) begin
               pd_reg <= 1'b1; // see RQ2
            end else if (mode_reg == M_RELEASE) begin
               pd_reg <= 1'b0; // see RQ5
            end
         end else begin
            timer_reg <= timer_reg - 32'h0000_0001;
         end
      end else if (csRise) begin
         if (opcode_reg == OP_POWER_DOWN && exactOpcode) begin
            mode_reg <= M_ENTRY; // see RQ1
            timer_reg <= ENTRY_CYC - 1;
         end else if (opcode_reg == OP_RELEASE && pd_reg) begin
            mode_reg <= M_RELEASE;
            // longer frame means the identity was read as well
            timer_reg <= exactOpcode ? REL1_CYC - 1 : REL2_CYC - 1; // see RQ7
         end else if (opcode_reg == OP_WREN && exactOpcode) begin
            wel_reg <= 1'b1;
         end else if (opcode_reg == OP_WRDI && exactOpcode) begin
            wel_reg <= 1'b0;
         end else if (opcode_reg == OP_SEC_ERASE && exactOpcode && wel_reg &&
                      !securityLockBit) begin
            mode_reg <= M_ERASE; // see RQ12 RQ13 RQ16
            timer_reg <= SE_CYC - 1; // see RQ14
            eraseIdx_reg <= 12'h000;
            wel_reg <= 1'b0; // see RQ15
         end else if (opcode_reg == OP_SEC_PROG && progWrote_reg) begin
            mode_reg <= M_PROGRAM;
            timer_reg <= PP_CYC - 1; // see RQ19
            wel_reg <= 1'b0; // see RQ15
         end
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign link.misoDrive = tx_reg[7];
   assign link.misoOe = outEn_reg & ~csHigh;
   assign deepPowerDown = pd_reg;
   assign writeInProgress = write_in_progress;
   assign writeEnableLatch = wel_reg;

endmodule : sfo_flash_dev
`default_nettype wire

// file: design/sfo_host_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module sfo_host_ctrl
   import sfo_pkg::*;
#(
   parameter int unsigned HALF_CYC = SCK_HALF_CYC,
   parameter int unsigned GAP_CYC = CS_GAP_CYC
)(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // serial link
   sfo_spi_if.host link,
   // command request
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic [7:0] cmdOpcode,
   input wire logic cmdAddrEn,
   input wire logic [23:0] cmdAddr,
   input wire logic [1:0] cmdDummy,
   input wire logic [10:0] cmdLen,
   input wire logic cmdRead,
   // write data
   input wire logic [7:0] wrData,
   output logic wrTake,
   // read data
   output logic [7:0] rdData,
   output logic rdValid
);

   typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} sfo_hstate_t;

   // ************************************************************
   // data in synchroniser
   // ************************************************************
   logic misoMeta_reg;
   logic misoSync_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         misoMeta_reg <= 1'b1;
         misoSync_reg <= 1'b1;
      end else begin
         misoMeta_reg <= link.miso;
         misoSync_reg <= misoMeta_reg;
      end
   end

   sfo_hstate_t state_reg;
   logic [15:0] div_reg;
   logic csN_reg;
   logic sck_reg;
   logic [7:0] tx_reg;
   logic [7:0] rx_reg;
   logic [2:0] bitPos_reg;
   logic [11:0] byteIdx_reg;
   logic [11:0] total_reg;
   logic [11:0] nAddr_reg;
   logic [11:0] hdr_reg;
   logic [23:0] addrSh_reg;
   logic read_reg;

   // ************************************************************
   // next byte selection
   // ************************************************************
   wire divDone = (div_reg == 16'h0000);
   wire [11:0] nextIdx = byteIdx_reg + 12'h001;
   wire nextIsAddr = nextIdx <= nAddr_reg;
   wire nextIsData = nextIdx >= hdr_reg;
   wire curIsData = byteIdx_reg >= hdr_reg;
   wire lastByte = nextIdx == total_reg;
   wire [7:0] rxNext = {rx_reg[6:0], misoSync_reg};
   wire [7:0] nextByte = nextIsAddr ? addrSh_reg[23:16] :
                         !nextIsData ? 8'h00 :
                         read_reg ? 8'hFF : wrData;
   wire [11:0] addrBytes = cmdAddrEn ? 12'h003 : 12'h000;
   wire [11:0] startHdr = 12'h001 + addrBytes + {10'h000, cmdDummy};

   // ************************************************************
   // frame sequencer; the frame length is fixed when taken, so a
   // one-byte command always ends right after its eighth bit
   // ************************************************************
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= H_IDLE;
         div_reg <= 16'h0000;
         csN_reg <= 1'b1;
         sck_reg <= 1'b0;
         tx_reg <= 8'h00;
         rx_reg <= 8'h00;
         bitPos_reg <= 3'h0;
         byteIdx_reg <= 12'h000;
         total_reg <= 12'h000;
         nAddr_reg <= 12'h000;
         hdr_reg <= 12'h000;
         addrSh_reg <= 24'h000000;
         read_reg <= 1'b0;
         rdData <= 8'h00;
         rdValid <= 1'b0;
         wrTake <= 1'b0;
      end else begin
         rdValid <= 1'b0;
         wrTake <= 1'b0;
         if (!divDone) begin
            div_reg <= div_reg - 16'h0001;
         end
         case (state_reg)
            H_IDLE: begin
               if (cmdValid) begin
                  csN_reg <= 1'b0;
                  tx_reg <= cmdOpcode; // see RQ1 RQ13
                  bitPos_reg <= 3'h0;
                  byteIdx_reg <= 12'h000;
                  nAddr_reg <= addrBytes;
                  hdr_reg <= startHdr; // see RQ6 RQ9
                  total_reg <= startHdr + {1'b0, cmdLen}; // see RQ17
                  addrSh_reg <= cmdAddr;
                  read_reg <= cmdRead;
                  div_reg <= HALF_CYC[15:0] - 16'h0001;
                  state_reg <= H_LOW;
               end
            end
            H_LOW: begin
               if (divDone) begin
                  sck_reg <= 1'b1;
                  div_reg <= HALF_CYC[15:0] - 16'h0001;
                  state_reg <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (divDone) begin
                  // sample late in the high phase to cover both synchronisers
                  sck_reg <= 1'b0;
                  rx_reg <= rxNext;
                  bitPos_reg <= bitPos_reg + 3'h1;
                  div_reg <= HALF_CYC[15:0] - 16'h0001;
                  state_reg <= H_LOW;
                  if (bitPos_reg == 3'h7) begin
                     byteIdx_reg <= nextIdx;
                     if (curIsData && read_reg) begin
                        rdData <= rxNext;
                        rdValid <= 1'b1;
                     end
                     if (lastByte) begin
                        csN_reg <= 1'b1;
                        div_reg <= GAP_CYC[15:0] - 16'h0001; // see RQ5 RQ7
                        state_reg <= H_GAP;
                     end else begin
                        tx_reg <= nextByte;
                        wrTake <= nextIsData & ~read_reg;
                        if (nextIsAddr) begin
                           addrSh_reg <= {addrSh_reg[15:0], 8'h00};
                        end
                     end
                  end else begin
                     tx_reg <= {tx_reg[6:0], 1'b0};
                  end
               end
            end
            default: begin
               if (divDone) begin
                  state_reg <= H_IDLE;
               end
            end
         endcase
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign cmdReady = (state_reg == H_IDLE);
   assign link.csN = csN_reg;
   assign link.sck = sck_reg;
   assign link.mosi = tx_reg[7] & ~csN_reg;

endmodule : sfo_host_ctrl
`default_nettype wire

// file: bench/sfo_link_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// link and flash state checks
// ********************
module sfo_link_assertions (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // link
   input wire logic csN,
   input wire logic sck,
   input wire logic misoDrive,
   input wire logic misoOe,
   // flash state
   input wire logic deepPowerDown,
   input wire logic writeInProgress,
   input wire logic writeEnableLatch
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // a self-timed cycle opens; several checks hang on it
   sequence cycleOpen;
      $rose(writeInProgress);
   endsequence
   // deselected long enough that the synchroniser has let go
   sequence linkIdle;
      csN [*6];
   endsequence
   reset_awake_a: assert property (
      $fell(rst) |-> !deepPowerDown && !writeInProgress)
      else $error("flash busy or asleep after reset");
   line_release_a: assert property (
      linkIdle |-> !misoOe)
      else $error("data line driven while deselected");
   shift_on_fall_a: assert property (
      misoOe && $past(misoOe) && $changed(misoDrive) |-> !sck)
      else $error("output bit changed while serial clock high");
   cycle_start_a: assert property (
      cycleOpen |-> csN && $past(writeEnableLatch))
      else $error("write cycle began without latch or inside a frame");
   cycle_length_a: assert property (
      cycleOpen |-> writeInProgress [*8])
      else $error("write cycle ended too soon");
   latch_clear_a: assert property (
      cycleOpen ##1 writeInProgress |-> !writeEnableLatch)
      else $error("latch still set inside write cycle");
   asleep_quiet_a: assert property (
      $rose(writeInProgress) || $rose(writeEnableLatch) |-> !deepPowerDown)
      else $error("command acted on while powered down");
   sleep_entry_a: assert property (
      $rose(deepPowerDown) |-> csN && !writeInProgress)
      else $error("power-down entered inside a frame or cycle");
   wake_quiet_a: assert property (
      $fell(deepPowerDown) |-> csN && $past(csN, 8))
      else $error("wake-up while selected");
endmodule : sfo_link_assertions
`default_nettype wire

// file: bench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ********************
// both ends joined, checked against an integer model
// ********************
module testbench import sfo_pkg::*; ;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cmdValid = 1'b0;
   logic cmdAddrEn = 1'b0;
   logic cmdRead = 1'b0;
   logic securityLockBit = 1'b0;
   logic [3:1] registerLock = 3'h0;
   logic [7:0] cmdOpcode = 8'h00;
   logic [7:0] wrData = 8'h00;
   logic [23:0] cmdAddr = 24'h000000;
   logic [1:0] cmdDummy = 2'h0;
   logic [10:0] cmdLen = 11'h000;
   logic cmdReady, wrTake, rdValid, deepPowerDown, writeInProgress, writeEnableLatch;
   logic [7:0] rdData;
   logic [7:0] got[$];
   logic [31:0] seed = 32'h00009ACB;
   int mem[3072];
   int mWel = 0;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   int takes = 0;
   sfo_spi_if sfo_spi_if_i ();
   sfo_flash_dev #(.ENTRY_CYC(20), .REL1_CYC(20), .SE_CYC(4000), .PP_CYC(2000))
      sfo_flash_dev_i (.link(sfo_spi_if_i.device), .*);
   sfo_host_ctrl #(.GAP_CYC(480)) sfo_host_ctrl_i (.link(sfo_spi_if_i.host), .*);
   sfo_link_assertions sfo_link_assertions_i (.csN(sfo_spi_if_i.csN), .sck(sfo_spi_if_i.sck),
      .misoDrive(sfo_spi_if_i.misoDrive), .misoOe(sfo_spi_if_i.misoOe), .*);
   // clock
   initial forever #2 clock = ~clock;
   // read bytes kept in arrival order; the ceiling cuts a hang short
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (rdValid === 1'b1) got.push_back(rdData);
      if (wrTake === 1'b1) takes++;
      if (cycles == 90000) begin
         mismatches++;
         finish_test();
      end
   end
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction : rnd
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic finish_test();
      $display("mismatches %0d checks %0d", mismatches, n_checks);
      if (mismatches == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   // one whole frame; returns on an edge once the host is idle again
   task automatic cmd(input logic [7:0] op, input logic ae, input logic [23:0] a,
      input logic [1:0] dm, input int len, input logic rd, input logic [7:0] d);
      int i;
      got.delete();
      takes = 0;
      cmdOpcode <= op;
      cmdAddrEn <= ae;
      cmdAddr <= a;
      cmdDummy <= dm;
      cmdLen <= 11'(len);
      cmdRead <= rd;
      wrData <= d;
      cmdValid <= 1'b1;
      @(posedge clock);
      cmdValid <= 1'b0;
      #1;
      for (i = 0; i < 3000 && cmdReady !== 1'b1; i++) @(posedge clock) #1;
      @(posedge clock);
   endtask : cmd
   task automatic wren();
      cmd(OP_WREN, 0, 0, 0, 0, 0, 0);
      mWel = 1;
   endtask : wren
   task automatic stat(input int e);
      cmd(OP_STATUS, 0, 0, 0, 1, 1, 0);
      chk(got[0], e);
   endtask : stat
   // model keeps only what a latched, unlocked program may clear
   task automatic prog(input logic [23:0] a);
      logic [7:0] d;
      d = rnd();
      cmd(OP_SEC_PROG, 1, a, 0, 1, 0, d);
      chk(takes, 1);
      if (mWel == 1 && registerLock[a[13:12]] !== 1'b1) begin
         mem[(int'(a[13:12]) - 1) * 1024 + a[9:0]] &= d;
         mWel = 0;
      end
   endtask : prog
   task automatic rd(input logic [23:0] a, input int n);
      int b;
      b = (int'(a[13:12]) - 1) * 1024;
      cmd(OP_SEC_READ, 1, a, 1, n, 1, 0);
      chk(got.size(), n);
      for (int i = 0; i < n; i++) chk(got[i], mem[b + (a[9:0] + i) % 1024]);
   endtask : rd
   task automatic idle();
      int i;
      #1;
      for (i = 0; i < 5000 && writeInProgress !== 1'b0; i++) @(posedge clock) #1;
      chk(writeInProgress, 0);
      @(posedge clock);
   endtask : idle
   // main sequence
   initial begin
      foreach (mem[i]) mem[i] = 255;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock) #1;
      chk(deepPowerDown, 0);
      @(posedge clock);
      stat(0);
      prog(24'h001005);
      rd(24'h001005, 1);
      for (int r = 1; r < 4; r++) begin
         wren();
         stat(2);
         prog({8'h00, 4'(r), 12'h3FF});
         chk(writeInProgress, 1);
         stat(1);
         cmd(OP_RELEASE, 0, 0, 3, 1, 1, 0);
         chk(got[0], 8'hFF);
         idle();
         wren();
         prog({8'h00, 4'(r), 12'h000});
         idle();
         rd({8'h00, 4'(r), 12'h3FE}, 4);
      end
      registerLock <= 3'h2;
      wren();
      prog(24'h002010);
      chk(writeInProgress, 0);
      rd(24'h002010, 1);
      registerLock <= 3'h0;
      cmd(OP_WRDI, 0, 0, 0, 0, 0, 0);
      mWel = 0;
      cmd(OP_SEC_ERASE, 0, 0, 0, 0, 0, 0);
      chk(writeInProgress, 0);
      wren();
      securityLockBit <= 1'b1;
      cmd(OP_SEC_ERASE, 0, 0, 0, 0, 0, 0);
      chk(writeInProgress, 0);
      securityLockBit <= 1'b0;
      cmd(OP_SEC_ERASE, 1, 0, 0, 0, 0, 0);
      chk(writeInProgress, 0);
      cmd(OP_SEC_ERASE, 0, 0, 0, 0, 0, 0);
      chk(writeInProgress, 1);
      stat(1);
      idle();
      foreach (mem[i]) mem[i] = 255;
      rd(24'h0033FF, 2);
      cmd(OP_POWER_DOWN, 0, 0, 0, 1, 0, 8'h00);
      chk(deepPowerDown, 0);
      cmd(OP_POWER_DOWN, 0, 0, 0, 0, 0, 0);
      chk(deepPowerDown, 1);
      wren();
      mWel = 0;
      stat(255);
      cmd(OP_RELEASE, 0, 0, 0, 0, 0, 0);
      chk(deepPowerDown, 0);
      stat(0);
      cmd(OP_POWER_DOWN, 0, 0, 0, 0, 0, 0);
      cmd(OP_RELEASE, 0, 0, 3, 2, 1, 0);
      chk({deepPowerDown, got[0], got[1]}, {1'b0, DEV_ID_DEFAULT, DEV_ID_DEFAULT});
      finish_test();
   end
endmodule : testbench
`default_nettype wire
